// ### rtl/erb_port.sv
// What this block does
// - 9-kbit array with input and output registers
// - single, true dual, pseudo dual or FIFO
// - SP/TDP ports: 8Kx1, 4Kx2, 2Kx4, 1Kx9
// - PDP and FIFO also allow 512x18
// - each port picks its own width
// - bits run word 0 LSB-MSB, then word 1
// - optional preload from user flash store
// - zero pattern skips flash, regions may be shared
// - ROM: preload and keep writes disabled
// - address and write data registered before array
// - output register only when selected
//
// package of constants plus the per-port register stage.
// assumes every user port runs on the single block clock clk.
`timescale 1ns/1ps

package erb_pkg;
  // ****************************************
  // array geometry
  // ****************************************
  localparam int unsigned ERB_DW      = 18;
  localparam int unsigned ERB_AW      = 13;
  localparam int unsigned ERB_BW      = 14;
  localparam int unsigned ERB_FAW     = 16;
  localparam int unsigned ERB_NBITS   = 9216;
  localparam logic [13:0] ERB_CAP_FULL   = 14'h2400;
  localparam logic [13:0] ERB_CAP_NARROW = 14'h2000;
  localparam logic [10:0] ERB_LOAD_BYTES = 11'h480;

  // ****************************************
  // modes and width codes
  // ****************************************
  localparam logic [1:0] ERB_MODE_SP   = 2'h0;
  localparam logic [1:0] ERB_MODE_TDP  = 2'h1;
  localparam logic [1:0] ERB_MODE_PDP  = 2'h2;
  localparam logic [1:0] ERB_MODE_FIFO = 2'h3;
  localparam logic [2:0] ERB_W1  = 3'h0;
  localparam logic [2:0] ERB_W2  = 3'h1;
  localparam logic [2:0] ERB_W4  = 3'h2;
  localparam logic [2:0] ERB_W9  = 3'h3;
  localparam logic [2:0] ERB_W18 = 3'h4;

  typedef enum logic [4:0] {
    ERB_LD_IDLE  = 5'h01,
    ERB_LD_CLEAR = 5'h02,
    ERB_LD_FETCH = 5'h04,
    ERB_LD_WAIT  = 5'h08,
    ERB_LD_DONE  = 5'h10
  } erb_ld_e;

  // 18-bit only where the mode allows it, else fall back to 9
  function automatic logic [2:0] erb_eff_code(input logic [2:0] code, input logic wide_ok);
    if (code == ERB_W18 && !wide_ok) begin
      return ERB_W9;
    end
    return (code > ERB_W18) ? ERB_W1 : code;
  endfunction

  function automatic logic [4:0] erb_wbits(input logic [2:0] code);
    case (code)
      ERB_W2:  return 5'h02;
      ERB_W4:  return 5'h04;
      ERB_W9:  return 5'h09;
      ERB_W18: return 5'h12;
      default: return 5'h01;
    endcase
  endfunction

  // linear bit address of a word, same mapping for every width
  function automatic logic [13:0] erb_word_base(input logic [2:0] code, input logic [12:0] addr);
    case (code)
      ERB_W2:  return {1'b0, addr[11:0], 1'b0};
      ERB_W4:  return {1'b0, addr[10:0], 2'b00};
      ERB_W9:  return 14'({4'h0, addr[9:0]} * 14'h0009);
      ERB_W18: return 14'({5'h00, addr[8:0]} * 14'h0012);
      default: return {1'b0, addr};
    endcase
  endfunction
endpackage

module erb_port
  import erb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        oreg_en,
  input  wire logic        in_en,
  input  wire logic        in_we,
  input  wire logic [13:0] in_base,
  input  wire logic [17:0] in_wdata,
  input  wire logic [4:0]  in_wbits,
  input  wire logic [17:0] arr_dout,
  output logic             q_en,
  output logic             q_we,
  output logic [13:0]      q_base,
  output logic [17:0]      q_wdata,
  output logic [4:0]       q_wbits,
  output logic [17:0]      rdata
);
  typedef struct packed {
    logic        en;
    logic        we;
    logic [13:0] base;
    logic [17:0] wdata;
    logic [4:0]  wbits;
    logic [17:0] pipe;
    logic [17:0] rdata;
  } erb_port_s;

  erb_port_s st_reg;
  erb_port_s st_next;

  // ****************************************
  // input capture and read pipeline
  // ****************************************
  always_comb begin
    st_next       = st_reg;
    st_next.en    = in_en;
    st_next.we    = in_en & in_we;
    st_next.pipe  = arr_dout;
    // bypass saves a cycle, register buys clock-to-out margin
    st_next.rdata = oreg_en ? st_reg.pipe : arr_dout;
    if (in_en) begin
      st_next.base  = in_base;
      st_next.wdata = in_wdata;
      st_next.wbits = in_wbits;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg       <= '0;
      st_reg.wbits <= 5'h01;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q_en    = st_reg.en;
  assign q_we    = st_reg.we;
  assign q_base  = st_reg.base;
  assign q_wdata = st_reg.wdata;
  assign q_wbits = st_reg.wbits;
  assign rdata   = st_reg.rdata;

  // ****************************************
  // checks
  // ****************************************
  chk_capture_addr: assert property (@(posedge clk) disable iff (!rst_n)
    in_en |=> q_base == $past(in_base) && q_wdata == $past(in_wdata))
    else $error("address not captured at input");
  // case equality: array bits stay unset until preload, the pipe must still follow
  chk_bypass_lat: assert property (@(posedge clk) disable iff (!rst_n)
    !oreg_en |=> rdata === $past(arr_dout))
    else $error("bypass read data not one cycle");
  chk_oreg_lat: assert property (@(posedge clk) disable iff (!rst_n)
    oreg_en ##1 oreg_en |=> rdata === $past(arr_dout, 2))
    else $error("registered read data not two cycles");
endmodule

// ### rtl/erb_ram.sv
// embedded_ram_block top: array, mode steering, fifo pointers and preload.
// assumes user logic and the user_flash_store reader share clk.
`timescale 1ns/1ps

module erb_ram
  import erb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [1:0]  mode,
  input  wire logic        rom_mode,
  input  wire logic [2:0]  a_width,
  input  wire logic [2:0]  b_width,
  input  wire logic        a_oreg,
  input  wire logic        b_oreg,
  input  wire logic        a_en,
  input  wire logic        a_we,
  input  wire logic [12:0] a_addr,
  input  wire logic [17:0] a_wdata,
  output logic [17:0]      a_rdata,
  input  wire logic        b_en,
  input  wire logic        b_we,
  input  wire logic [12:0] b_addr,
  input  wire logic [17:0] b_wdata,
  output logic [17:0]      b_rdata,
  output logic             fifo_full,
  output logic             fifo_empty,
  input  wire logic        cfg_start,
  input  wire logic        cfg_zero,
  input  wire logic [15:0] cfg_region_base,
  output logic             flash_req,
  output logic [15:0]      flash_addr,
  input  wire logic        flash_rvalid,
  input  wire logic [7:0]  flash_rdata,
  output logic             init_done
);
  typedef struct packed {
    erb_ld_e     ld_state;
    logic [10:0] ld_idx;
    logic        flash_req;
    logic [15:0] flash_addr;
    logic        init_done;
    logic [13:0] wptr;
    logic [13:0] rptr;
    logic [13:0] fill;
    logic        full;
    logic        empty;
  } erb_s;

  erb_s st_reg;
  erb_s st_next;

  logic        mem [0:ERB_NBITS-1];
  logic        is_fifo;
  logic        wide_ok;
  logic        busy;
  logic [2:0]  a_code;
  logic [2:0]  b_code;
  logic [4:0]  a_wbits;
  logic [4:0]  b_wbits;
  logic [13:0] cap;
  logic        push;
  logic        pop;
  logic        a_go;
  logic        a_wr;
  logic        b_go;
  logic        b_wr;
  logic [13:0] a_base;
  logic [13:0] b_base;
  logic        a_q_en;
  logic        a_q_we;
  logic [13:0] a_q_base;
  logic [17:0] a_q_wdata;
  logic [4:0]  a_q_wbits;
  logic        b_q_en;
  logic        b_q_we;
  logic [13:0] b_q_base;
  logic [17:0] b_q_wdata;
  logic [4:0]  b_q_wbits;
  logic [17:0] a_dout;
  logic [17:0] b_dout;
  logic        ld_wr;
  logic [7:0]  ld_byte;

  // bit index with wrap; only the fifo ever wraps below the full array
  function automatic int bit_idx(input logic [13:0] base, input int i, input logic [13:0] c);
    int s;
    s = int'(base) + i;
    if (s >= int'(c)) begin
      s = s - int'(c);
    end
    return s;
  endfunction

  // ****************************************
  // mode steering
  // ****************************************
  always_comb begin
    is_fifo = (mode == ERB_MODE_FIFO);
    wide_ok = (mode == ERB_MODE_PDP) || is_fifo;
    busy    = (st_reg.ld_state != ERB_LD_IDLE) && (st_reg.ld_state != ERB_LD_DONE);
    a_code  = erb_eff_code(a_width, wide_ok);
    b_code  = erb_eff_code(b_width, wide_ok);
    a_wbits = erb_wbits(a_code);
    b_wbits = erb_wbits(b_code);
    // 1/2/4-bit words leave the ninth bits unused
    cap     = (is_fifo && a_code >= ERB_W9 && b_code >= ERB_W9) ? ERB_CAP_FULL :
              (is_fifo ? ERB_CAP_NARROW : ERB_CAP_FULL);
    push    = is_fifo & a_en & a_we & ~st_reg.full & ~busy & ~rom_mode;
    pop     = is_fifo & b_en & ~st_reg.empty & ~busy;
    a_go    = is_fifo ? push : (a_en & ~busy);
    a_wr    = a_go & a_we & ~rom_mode;
    b_go    = is_fifo ? pop : (b_en & ~busy & (mode != ERB_MODE_SP));
    b_wr    = b_go & b_we & ~rom_mode & (mode == ERB_MODE_TDP);
    a_base  = is_fifo ? st_reg.wptr : erb_word_base(a_code, a_addr);
    b_base  = is_fifo ? st_reg.rptr : erb_word_base(b_code, b_addr);
  end

  // ****************************************
  // port register stages
  // ****************************************
  erb_port u_port_a (
    .clk      (clk),
    .rst_n    (rst_n),
    .oreg_en  (a_oreg),
    .in_en    (a_go),
    .in_we    (a_wr),
    .in_base  (a_base),
    .in_wdata (a_wdata),
    .in_wbits (a_wbits),
    .arr_dout (a_dout),
    .q_en     (a_q_en),
    .q_we     (a_q_we),
    .q_base   (a_q_base),
    .q_wdata  (a_q_wdata),
    .q_wbits  (a_q_wbits),
    .rdata    (a_rdata)
  );

  erb_port u_port_b (
    .clk      (clk),
    .rst_n    (rst_n),
    .oreg_en  (b_oreg),
    .in_en    (b_go),
    .in_we    (b_wr),
    .in_base  (b_base),
    .in_wdata (b_wdata),
    .in_wbits (b_wbits),
    .arr_dout (b_dout),
    .q_en     (b_q_en),
    .q_we     (b_q_we),
    .q_base   (b_q_base),
    .q_wdata  (b_q_wdata),
    .q_wbits  (b_q_wbits),
    .rdata    (b_rdata)
  );

  // ****************************************
  // array read and write
  // ****************************************
  // reads see the array before a same-cycle write lands
  always_comb begin
    a_dout = '0;
    b_dout = '0;
    for (int i = 0; i < ERB_DW; i++) begin
      if (5'(i) < a_q_wbits) begin
        a_dout[i] = mem[bit_idx(a_q_base, i, cap)];
      end
      if (5'(i) < b_q_wbits) begin
        b_dout[i] = mem[bit_idx(b_q_base, i, cap)];
      end
    end
  end

  assign ld_wr   = (st_reg.ld_state == ERB_LD_CLEAR) ||
                   (st_reg.ld_state == ERB_LD_WAIT && flash_rvalid);
  assign ld_byte = (st_reg.ld_state == ERB_LD_CLEAR) ? 8'h00 : flash_rdata;

  // no reset on the array itself; contents come from preload or writes
  always_ff @(posedge clk) begin
    if (ld_wr) begin
      for (int i = 0; i < 8; i++) begin
        mem[int'(st_reg.ld_idx) * 8 + i] <= ld_byte[i];
      end
    end
    for (int i = 0; i < ERB_DW; i++) begin
      if (a_q_we && 5'(i) < a_q_wbits) begin
        mem[bit_idx(a_q_base, i, cap)] <= a_q_wdata[i];
      end
      if (b_q_we && 5'(i) < b_q_wbits) begin
        mem[bit_idx(b_q_base, i, cap)] <= b_q_wdata[i];
      end
    end
  end

  // ****************************************
  // fifo pointers and preload sequencer
  // ****************************************
  always_comb begin
    logic [14:0] sum;
    logic [14:0] nfill;
    sum     = '0;
    nfill   = '0;
    st_next = st_reg;
    if (push) begin
      sum = {1'b0, st_reg.wptr} + {10'h000, a_wbits};
      st_next.wptr = (sum >= {1'b0, cap}) ? 14'(sum - {1'b0, cap}) : sum[13:0];
    end
    if (pop) begin
      sum = {1'b0, st_reg.rptr} + {10'h000, b_wbits};
      st_next.rptr = (sum >= {1'b0, cap}) ? 14'(sum - {1'b0, cap}) : sum[13:0];
    end
    nfill = {1'b0, st_reg.fill} + (push ? {10'h000, a_wbits} : 15'h0000)
          - (pop ? {10'h000, b_wbits} : 15'h0000);
    st_next.fill  = nfill[13:0];
    st_next.full  = (nfill + {10'h000, a_wbits}) > {1'b0, cap};
    st_next.empty = nfill < {10'h000, b_wbits};
    if (!is_fifo) begin
      st_next.wptr  = '0;
      st_next.rptr  = '0;
      st_next.fill  = '0;
      st_next.full  = 1'b0;
      st_next.empty = 1'b1;
    end
    st_next.flash_req = 1'b0;
    case (st_reg.ld_state)
      ERB_LD_IDLE, ERB_LD_DONE: begin
        if (cfg_start) begin
          st_next.ld_idx    = '0;
          st_next.init_done = 1'b0;
          // all-zero pattern is filled locally, no flash traffic
          st_next.ld_state  = cfg_zero ? ERB_LD_CLEAR : ERB_LD_FETCH;
        end
      end
      ERB_LD_CLEAR, ERB_LD_WAIT: begin
        if (ld_wr) begin
          st_next.ld_idx = st_reg.ld_idx + 11'h001;
          if (st_reg.ld_idx == ERB_LOAD_BYTES - 11'h001) begin
            st_next.ld_state  = ERB_LD_DONE;
            st_next.init_done = 1'b1;
          end else if (st_reg.ld_state == ERB_LD_WAIT) begin
            st_next.ld_state = ERB_LD_FETCH;
          end
        end
      end
      ERB_LD_FETCH: begin
        // equal base offsets let several blocks share one region
        st_next.flash_req  = 1'b1;
        st_next.flash_addr = cfg_region_base + {5'h00, st_reg.ld_idx};
        st_next.ld_state   = ERB_LD_WAIT;
      end
      default: st_next.ld_state = ERB_LD_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg          <= '0;
      st_reg.ld_state <= ERB_LD_IDLE;
      st_reg.empty    <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign fifo_full  = st_reg.full;
  assign fifo_empty = st_reg.empty;
  assign flash_req  = st_reg.flash_req;
  assign flash_addr = st_reg.flash_addr;
  assign init_done  = st_reg.init_done;

  // ****************************************
  // checks
  // ****************************************
  chk_rom_no_write: assert property (@(posedge clk) disable iff (!rst_n)
    rom_mode |=> !a_q_we && !b_q_we)
    else $error("write reached array in rom mode");
  chk_pdp_b_ro: assert property (@(posedge clk) disable iff (!rst_n)
    mode == ERB_MODE_PDP |=> !b_q_we)
    else $error("pseudo dual port b wrote");
  chk_sp_b_idle: assert property (@(posedge clk) disable iff (!rst_n)
    mode == ERB_MODE_SP |=> !b_q_en)
    else $error("single port b active");
  chk_narrow_width: assert property (@(posedge clk) disable iff (!rst_n)
    !wide_ok |-> a_wbits <= 5'h09 && b_wbits <= 5'h09)
    else $error("18-bit width outside pdp or fifo");
  chk_full_push: assert property (@(posedge clk) disable iff (!rst_n)
    is_fifo && st_reg.full ##1 is_fifo |-> st_reg.wptr == $past(st_reg.wptr))
    else $error("push accepted while full");
  chk_load_block: assert property (@(posedge clk) disable iff (!rst_n)
    busy |=> !a_q_en && !b_q_en)
    else $error("port access during preload");
  chk_zero_noflash: assert property (@(posedge clk) disable iff (!rst_n)
    st_reg.ld_state == ERB_LD_CLEAR |=> !flash_req)
    else $error("flash read during zero fill");
  chk_fetch_addr: assert property (@(posedge clk) disable iff (!rst_n)
    st_reg.ld_state == ERB_LD_FETCH |=> flash_req &&
      flash_addr == $past(cfg_region_base) + {5'h00, $past(st_reg.ld_idx)})
    else $error("flash fetch address wrong");

  cov_zero_fill: cover property (@(posedge clk) disable iff (!rst_n)
    st_reg.ld_state == ERB_LD_CLEAR ##1 st_reg.ld_state == ERB_LD_DONE);
  cov_flash_load: cover property (@(posedge clk) disable iff (!rst_n)
    st_reg.ld_state == ERB_LD_WAIT ##1 st_reg.ld_state == ERB_LD_DONE);
  cov_fifo_full: cover property (@(posedge clk) disable iff (!rst_n) is_fifo && fifo_full);
  cov_tdp_both: cover property (@(posedge clk) disable iff (!rst_n) a_q_we && b_q_we);
endmodule

// ### test/erb_flash_model.sv
// user_flash_store stand-in: answers byte reads after 1 or 3 cycles.
// assumes flash_req is a one-cycle pulse with one read open at a time.
`timescale 1ns/1ps

module erb_flash_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        slow,
  input  wire logic [15:0] base,
  input  wire logic        flash_req,
  input  wire logic [15:0] flash_addr,
  output logic             flash_rvalid,
  output logic [7:0]       flash_rdata,
  output logic [15:0]      n_req,
  output logic             addr_err
);
  logic [1:0]  wait_reg;
  logic [15:0] addr_reg;

  // stored pattern, a plain function of the byte address
  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction

  // data lines toggle while idle so a stale byte is never mistaken
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_rvalid <= 1'b0;
      flash_rdata  <= 8'h00;
      n_req        <= 16'h0000;
      addr_err     <= 1'b0;
      wait_reg     <= 2'h0;
      addr_reg     <= 16'h0000;
    end else begin
      flash_rvalid <= 1'b0;
      flash_rdata  <= ~flash_rdata;
      if (flash_req) begin
        addr_reg <= flash_addr;
        wait_reg <= slow ? 2'h3 : 2'h1;
        n_req    <= n_req + 16'h0001;
        addr_err <= addr_err | (flash_addr !== base + n_req);
      end else if (wait_reg != 2'h0) begin
        wait_reg <= wait_reg - 2'h1;
        if (wait_reg == 2'h1) begin
          flash_rvalid <= 1'b1;
          flash_rdata  <= pat(addr_reg);
        end
      end
    end
  end
endmodule

// ### test/erb_ram_bench.sv
// self-checking bench for erb_ram: shadow bit array, read notes queued.
// assumes one 40 MHz clock for user ports and the flash model.
`timescale 1ns/1ps

module erb_ram_bench;
  import erb_pkg::*;

  typedef struct {logic [17:0] v; int due;} erb_note_s;

  logic        clk, rst_n, rom_mode, a_oreg, b_oreg, a_en, a_we, b_en, b_we;
  logic        cfg_start, cfg_zero, slow, fifo_full, fifo_empty;
  logic        flash_req, flash_rvalid, init_done, addr_err;
  logic [1:0]  mode;
  logic [2:0]  a_width, b_width;
  logic [12:0] a_addr, b_addr;
  logic [17:0] a_wdata, b_wdata, a_rdata, b_rdata;
  logic [15:0] cfg_region_base, flash_addr, n_req;
  logic [7:0]  flash_rdata;
  logic [9215:0] sh;
  logic [31:0] seed = 32'h7557EAC2;
  logic [8:0]  ff[$];
  erb_note_s   qa[$], qb[$];
  int          cyc, n_mismatch, num_checks, ad;

  erb_ram dut_u (.clk, .rst_n, .mode, .rom_mode, .a_width, .b_width, .a_oreg, .b_oreg,
    .a_en, .a_we, .a_addr, .a_wdata, .a_rdata, .b_en, .b_we, .b_addr, .b_wdata, .b_rdata,
    .fifo_full, .fifo_empty, .cfg_start, .cfg_zero, .cfg_region_base, .flash_req,
    .flash_addr, .flash_rvalid, .flash_rdata, .init_done);

  erb_flash_model flash_u (.clk, .rst_n, .slow, .base(cfg_region_base), .flash_req,
    .flash_addr, .flash_rvalid, .flash_rdata, .n_req, .addr_err);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  // 18 bits only in pseudo dual and fifo modes
  function automatic int wid(input logic [2:0] c);
    case (c)
      3'h1: return 2;
      3'h2: return 4;
      3'h3: return 9;
      3'h4: return mode[1] ? 18 : 9;
      default: return 1;
    endcase
  endfunction

  function automatic int rad(input logic [2:0] c);
    return int'(rnd() % ((wid(c) >= 9) ? 9216 / wid(c) : 8192 / wid(c)));
  endfunction

  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one request; driven now, captured next edge, data 1 or 2 edges later
  task automatic acc(input logic p, input logic we, input int word, input logic [17:0] d);
    int w;
    logic ok;
    logic [17:0] e;
    w = wid(p ? b_width : a_width);
    ok = !(p && mode == 2'h0) && !(we && (rom_mode || (p && mode[1])));
    e = 18'h00000;
    @(posedge clk);
    a_en <= !p;
    a_we <= we;
    a_addr <= 13'(word);
    a_wdata <= d;
    b_en <= p;
    b_we <= we;
    b_addr <= 13'(word);
    b_wdata <= d;
    if (mode == 2'h3 && !p) ff.push_back(d[8:0]);
    else if (mode == 2'h3) qb.push_back('{18'(ff.pop_front()), cyc + 3 + int'(b_oreg)});
    else if (ok && we) for (int i = 0; i < w; i++) sh[word * w + i] = d[i];
    else if (ok) begin
      for (int i = 0; i < w; i++) e[i] = sh[word * w + i];
      if (p) qb.push_back('{e, cyc + 3 + int'(b_oreg)});
      else qa.push_back('{e, cyc + 3 + int'(a_oreg)});
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk) begin
      a_en <= 1'b0;
      b_en <= 1'b0;
    end
  endtask

  task automatic cfg(input logic [1:0] m, input logic [2:0] wa, input logic [2:0] wb,
                     input logic oa, input logic ob, input logic rom);
    @(posedge clk);
    mode <= m;
    a_width <= wa;
    b_width <= wb;
    a_oreg <= oa;
    b_oreg <= ob;
    rom_mode <= rom;
    idle(2);
  endtask

  task automatic load(input logic z);
    int i;
    @(posedge clk);
    cfg_start <= 1'b1;
    cfg_zero <= z;
    @(posedge clk);
    cfg_start <= 1'b0;
    repeat (2) @(negedge clk);
    for (i = 0; i < 12000 && init_done !== 1'b1; i++) @(negedge clk);
    if (i == 12000) begin
      n_mismatch++;
      summarize();
    end
  endtask

  task automatic summarize();
    n_mismatch += qa.size() + qb.size();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ****************************************
  // monitor: oldest note taken when its cycle comes
  // ****************************************
  always @(negedge clk) begin
    cyc++;
    if (qa.size() > 0 && qa[0].due == cyc) begin
      check(a_rdata, qa[0].v);
      qa.delete(0);
    end
    if (qb.size() > 0 && qb[0].due == cyc) begin
      check(b_rdata, qb[0].v);
      qb.delete(0);
    end
  end

  initial begin
    #2000000;
    n_mismatch++;
    summarize();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {rom_mode, a_oreg, b_oreg, a_en, a_we, b_en, b_we, cfg_start, cfg_zero} = '0;
    {mode, a_width, b_width, a_addr, b_addr, a_wdata, b_wdata} = '0;
    rst_n = 1'b0;
    slow = 1'b0;
    cfg_region_base = 16'h1234;
    @(negedge clk);
    check({16'h0, fifo_empty, init_done}, 18'h00002);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    cfg(2'h0, 3'h4, 3'h3, 1'b0, 1'b0, 1'b0);
    load(1'b1);
    check(18'(n_req), 18'h00000);
    sh = '0;
    repeat (4) acc(1'b0, 1'b0, rad(a_width), 18'h0);
    idle(4);
    $display("test zero_fill done");
    slow <= 1'b1;
    load(1'b0);
    check(18'(n_req), 18'h00480);
    check(18'(addr_err), 18'h00000);
    for (int k = 0; k < 1152; k++) sh[8 * k +: 8] = flash_u.pat(cfg_region_base + 16'(k));
    $display("test flash_load done");
    for (int m = 0; m < 3; m++) begin
      for (int c = 0; c < 5; c++) begin
        cfg(2'(m), 3'(c), 3'((c + 2) % 5), 1'(rnd()), 1'(rnd()), 1'b0);
        repeat (3) begin
          ad = rad(a_width);
          acc(1'b0, 1'b1, ad, 18'(rnd()));
          acc(1'b0, 1'b0, ad, 18'h0);
        end
        acc(1'b1, 1'b1, rad(b_width), 18'(rnd()));
        repeat (4) acc(1'b0, 1'b0, rad(a_width), 18'h0);
        repeat (4) acc(1'b1, 1'b0, rad(b_width), 18'h0);
        idle(4);
      end
    end
    $display("test ram_modes done");
    cfg(2'h1, 3'h3, 3'h1, 1'b1, 1'b0, 1'b1);
    repeat (4) begin
      ad = rad(a_width);
      acc(1'b0, 1'b1, ad, 18'(rnd()));
      acc(1'b1, 1'b1, rad(b_width), 18'(rnd()));
      acc(1'b0, 1'b0, ad, 18'h0);
    end
    idle(4);
    $display("test rom done");
    cfg(2'h3, 3'h3, 3'h3, 1'b0, 1'b1, 1'b0);
    repeat (1024) acc(1'b0, 1'b1, 0, 18'(rnd()));
    idle(3);
    @(negedge clk);
    check(18'(fifo_full), 18'h00001);
    repeat (1024) acc(1'b1, 1'b0, 0, 18'h0);
    idle(6);
    @(negedge clk);
    check(18'(fifo_empty), 18'h00001);
    $display("test fifo done");
    summarize();
  end
endmodule
